// ### tb/rx_status_bank_props.sv
`timescale 1ns/1ps

// watches the status bank from its ports only; one clock domain
module rx_status_bank_props (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [9:0] i_addr,
	input wire logic i_rd,
	input wire logic i_cbit_mode,
	input wire logic [1:0] i_framing_err_count_select,
	input wire logic i_app_id_channel,
	input wire logic i_signal_absent,
	input wire logic i_cbit_parity_err,
	input wire logic i_oof_event,
	input wire logic i_mbit_err,
	input wire logic i_fbit_err,
	input wire logic [15:0] i_status_int_en,
	input wire logic i_port_int_en,
	input wire logic [15:0] o_rdata,
	input wire logic o_rd_valid,
	input wire logic [15:0] o_live_status,
	input wire logic o_int_req,
	input wire logic o_cbit_count_inc,
	input wire logic o_framing_count_inc
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	// framing event that the select field lets through
	logic fe_sel;
	always_comb begin
		case (i_framing_err_count_select)
			2'h0: fe_sel = i_oof_event;
			2'h1: fe_sel = i_mbit_err | i_fbit_err;
			2'h2: fe_sel = i_fbit_err;
			default: fe_sel = i_mbit_err;
		endcase
	end

	// loss of signal rises with its interrupt path open; first sample after reset only primes
	sequence s_los_rise;
		!$past(i_rst) && $rose(i_signal_absent) && i_status_int_en[0] && i_port_int_en;
	endsequence
	// live bit, change latch, then interrupt: a few edges at most
	sequence s_int_up;
		##[1:5] o_int_req;
	endsequence

	a_live_los_bit: assert property (!$past(i_rst) |-> o_live_status[0] == $past(i_signal_absent))
		else $error("live loss of signal bit wrong");
	a_live_mismatch_bit: assert property (!$past(i_rst) |-> o_live_status[11] == $past(i_cbit_mode ^ i_app_id_channel))
		else $error("live format mismatch bit wrong");
	a_cbit_inc_gate: assert property (!$past(i_rst) |-> o_cbit_count_inc == $past(i_cbit_parity_err && i_cbit_mode))
		else $error("c-bit count pulse wrong");
	a_framing_inc_sel: assert property (!$past(i_rst) |-> o_framing_count_inc == $past(fe_sel))
		else $error("framing count pulse ignores select");
	a_rd_valid_pulse: assert property (!$past(i_rst) |-> o_rd_valid == $past(i_rd))
		else $error("read valid not one cycle after read");
	a_unmapped_read_zero: assert property (i_rd && i_addr == 10'h100 |=> o_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_latch2_reserved_zero: assert property (i_rd && i_addr == 10'h12a |=> (o_rdata & 16'hf0f0) == 16'h0000)
		else $error("reserved bits of error latches not zero");
	a_port_int_gate: assert property (!i_port_int_en |=> !o_int_req)
		else $error("interrupt without port enable");
	a_los_int_chain: assert property (s_los_rise |-> s_int_up)
		else $error("loss of signal change gave no interrupt");
endmodule

// ### tb/rx_status_bank_tb.sv
`timescale 1ns/1ps

module rx_status_bank_tb;
	logic clk = 0;
	logic rst = 1;
	logic wr = 0, rd = 0, mode = 1, al = 0, pe = 0;
	logic [9:0] addr = 0;
	logic [15:0] wd = 0, lv = 0, sie = 0, eie = 0, rdat, live, v;
	logic [1:0] sel = 0;
	logic [5:0] ev = 0; // cbit, far, pbit, oof, mbit, fbit
	logic [3:0] nz = 0; // cbit, far, pbit, framing
	logic [3:0] inc;
	logic [11:0] av = 0;
	logic rv, irq;
	int error_cnt = 0, cmp_count = 0;
	int bl[10] = '{10, 9, 8, 7, 6, 4, 3, 2, 1, 0};

	always #2 clk = ~clk;

	rx_status_bank i_rx_status_bank (.i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
		.i_wdata(wd), .o_rdata(rdat), .o_rd_valid(rv), .i_cbit_mode(mode), .i_framing_err_count_select(sel),
		.i_app_id_channel(lv[10]), .i_quiet_signal(lv[9]), .i_unframed_all_ones(lv[8]),
		.i_multiframe_out(lv[7]), .i_severe_errored_frame(lv[6]), .i_frame_alignment_failure(lv[4]),
		.i_remote_defect(lv[3]), .i_alarm_indication(lv[2]), .i_out_of_framing(lv[1]),
		.i_signal_absent(lv[0]), .i_align_load(al), .i_align_value(av), .i_cbit_parity_err(ev[0]),
		.i_far_block_err(ev[1]), .i_pbit_parity_err(ev[2]), .i_oof_event(ev[3]), .i_mbit_err(ev[4]),
		.i_fbit_err(ev[5]), .i_cbit_cnt_nz(nz[3]), .i_far_block_cnt_nz(nz[2]), .i_pbit_cnt_nz(nz[1]),
		.i_framing_cnt_nz(nz[0]), .i_status_int_en(sie), .i_errors_int_en(eie), .i_port_int_en(pe),
		.o_cbit_count_inc(inc[3]), .o_far_block_count_inc(inc[2]), .o_pbit_count_inc(inc[1]),
		.o_framing_count_inc(inc[0]), .o_live_status(live), .o_int_req(irq));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one read strobe; data and valid show one edge later
	task automatic rdr(input logic [9:0] a, output logic [15:0] d);
		@(negedge clk);
		rd = 1;
		addr = a;
		@(negedge clk);
		rd = 0;
		d = rdat;
		chk(16'(rv), 16'h0001);
	endtask

	task automatic wrr(input logic [9:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = 1;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 0;
	endtask

	// one-cycle event pulses
	task automatic pulse(input logic [5:0] e);
		@(negedge clk);
		ev = e;
		@(negedge clk);
		ev = 0;
	endtask

	task automatic ld(input logic [11:0] x);
		@(negedge clk);
		al = 1;
		av = x;
		@(negedge clk);
		al = 0;
	endtask

	// does select s let event k (3 oof, 4 m-bit, 5 f-bit) through
	function automatic logic fe_hit(input logic [1:0] s, input int k);
		case (s)
			2'h0: return k == 3;
			2'h1: return k != 3;
			2'h2: return k == 5;
			default: return k == 4;
		endcase
	endfunction

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 0;
		step(2);
		rdr(10'h128, v);
		chk(v, 16'h0000);
		rdr(10'h12a, v);
		chk(v, 16'h0000);
		rdr(10'h100, v);
		chk(v, 16'h0000);
		$display("test reset done");
		// mismatch falls here: only the change latch of bit 10 may set
		lv[10] = 1;
		step(4);
		rdr(10'h128, v);
		chk(v, 16'h0400);
		foreach (bl[i]) begin
			lv = 16'h1 << bl[i];
			step(4);
			chk(live, lv | {4'h0, !lv[10], 11'h0});
			wrr(10'h128, 16'hffff);
			lv = 0;
			step(4);
			rdr(10'h128, v);
			chk(v, (16'h1 << bl[i]) | (bl[i] == 10 ? 16'h0800 : 16'h0));
		end
		// writing zero must leave latched bits alone
		wrr(10'h128, 16'h0000);
		rdr(10'h128, v);
		chk(v, 16'h0001);
		rdr(10'h124, v);
		chk(v, 16'h0800);
		$display("test live done");
		for (int m = 1; m >= 0; m--) begin
			mode = m[0];
			nz = 0;
			step(4);
			wrr(10'h12a, 16'hffff);
			step(2);
			nz = 4'hf;
			pulse(6'h3f);
			chk(16'(inc), m ? 16'h000f : 16'h0003);
			step(4);
			rdr(10'h126, v);
			chk(v, m ? 16'h000f : 16'h0003);
			rdr(10'h12a, v);
			chk(v, m ? 16'h0f0f : 16'h0303);
		end
		// count bits rise again on leaving M23; let that latch settle first
		mode = 1;
		step(4);
		$display("test counts done");
		for (int s = 0; s < 4; s++) begin
			for (int k = 3; k < 6; k++) begin
				sel = s[1:0];
				wrr(10'h12a, 16'hffff);
				pulse(6'h1 << k);
				chk(16'(inc[0]), 16'(fe_hit(sel, k)));
				step(2);
				rdr(10'h12a, v);
				chk(v, {7'h0, fe_hit(sel, k), 8'h0});
			end
		end
		$display("test framing select done");
		wrr(10'h128, 16'hffff);
		ld(12'h005);
		ld(12'h005);
		step(3);
		rdr(10'h128, v);
		chk(v, 16'h0000);
		ld(12'h006);
		step(3);
		rdr(10'h128, v);
		chk(v, 16'h0020);
		$display("test alignment done");
		wrr(10'h128, 16'hffff);
		sie = 16'h0001;
		lv[0] = 1;
		step(5);
		chk(16'(irq), 16'h0000);
		pe = 1;
		step(3);
		chk(16'(irq), 16'h0001);
		sie = 0;
		step(3);
		chk(16'(irq), 16'h0000);
		sie = 16'h0001;
		wrr(10'h128, 16'h0001);
		step(3);
		chk(16'(irq), 16'h0000);
		lv[0] = 0;
		step(3);
		wrr(10'h128, 16'hffff);
		lv[0] = 1;
		step(6);
		chk(16'(irq), 16'h0001);
		wrr(10'h128, 16'hffff);
		step(3);
		chk(16'(irq), 16'h0000);
		eie = 16'h0200;
		pulse(6'h04);
		step(3);
		chk(16'(irq), 16'h0001);
		// clear and a new error in one cycle: the error must survive
		fork
			pulse(6'h04);
			wrr(10'h12a, 16'hffff);
		join
		rdr(10'h12a, v);
		chk(v, 16'h0200);
		$display("test interrupt done");
		final_report;
	end

	// hang guard, well past the few hundred cycles the tests take
	initial begin
		#40000;
		error_cnt++;
		final_report;
	end
endmodule

bind rx_status_bank rx_status_bank_props i_rx_status_bank_props (.i_sys_clk, .i_rst, .i_addr, .i_rd,
	.i_cbit_mode, .i_framing_err_count_select, .i_app_id_channel, .i_signal_absent, .i_cbit_parity_err,
	.i_oof_event, .i_mbit_err, .i_fbit_err, .i_status_int_en, .i_port_int_en, .o_rdata, .o_rd_valid,
	.o_live_status, .o_int_req, .o_cbit_count_inc, .o_framing_count_inc);

// ### verilog/rx_status_bank.sv
`timescale 1ns/1ps

// Summary of operation
// - flag mismatch between programmed and received format
// - show received C11 format bit
// - show idle signal condition
// - show unframed all-ones condition
// - show out-of-multiframe condition
// - show severely errored frame condition
// - show loss-of-frame condition
// - show remote defect indication state
// - show alarm indication signal condition
// - show out-of-frame condition
// - show loss-of-signal condition
// - count bits follow counters being nonzero
// - M23 mode zeroes C-bit and far-end indicators
// - framing counter counts only selected event type
// - mismatch latch sets on rising edge only
// - change latches set on either edge
// - alignment latch sets on changed alignment load
// - error latches set on detected errors
// - framing error latch follows selected type
// - count latches set when count becomes nonzero
// - select codes: oof, m+f, f, m
// - framing count latch on nonzero rising
// - interrupt when latched, enabled, port enabled
module rx_status_bank #(
	parameter int ALIGN_W = rx_status_pkg::ALIGN_W_DEFAULT
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// register port
	input wire logic [rx_status_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [rx_status_pkg::REG_W-1:0] i_wdata,
	output logic [rx_status_pkg::REG_W-1:0] o_rdata,
	output logic o_rd_valid,
	// programmed framing format, 1 = C-bit, 0 = M23
	input wire logic i_cbit_mode,
	// framing error select field from the control register
	input wire logic [1:0] i_framing_err_count_select,
	// conditions from the receive frame processor
	input wire logic i_app_id_channel,
	input wire logic i_quiet_signal,
	input wire logic i_unframed_all_ones,
	input wire logic i_multiframe_out,
	input wire logic i_severe_errored_frame,
	input wire logic i_frame_alignment_failure,
	input wire logic i_remote_defect,
	input wire logic i_alarm_indication,
	input wire logic i_out_of_framing,
	input wire logic i_signal_absent,
	// frame alignment load strobe and value
	input wire logic i_align_load,
	input wire logic [ALIGN_W-1:0] i_align_value,
	// error detection pulses
	input wire logic i_cbit_parity_err,
	input wire logic i_far_block_err,
	input wire logic i_pbit_parity_err,
	input wire logic i_oof_event,
	input wire logic i_mbit_err,
	input wire logic i_fbit_err,
	// counter nonzero levels from the error counters
	input wire logic i_cbit_cnt_nz,
	input wire logic i_far_block_cnt_nz,
	input wire logic i_pbit_cnt_nz,
	input wire logic i_framing_cnt_nz,
	// interrupt enables kept outside this block
	input wire logic [rx_status_pkg::REG_W-1:0] i_status_int_en,
	input wire logic [rx_status_pkg::REG_W-1:0] i_errors_int_en,
	input wire logic i_port_int_en,
	// gated error pulses toward the counters
	output logic o_cbit_count_inc,
	output logic o_far_block_count_inc,
	output logic o_pbit_count_inc,
	output logic o_framing_count_inc,
	// live status word, also readable
	output logic [rx_status_pkg::REG_W-1:0] o_live_status,
	output logic o_int_req
);

	localparam int W = rx_status_pkg::REG_W;

	// alignment word must fit a sensible range
	initial begin
		if (ALIGN_W < 1 || ALIGN_W > 32) begin
			$error("ALIGN_W out of range");
		end
	end

	// registered live status word
	logic [W-1:0] live_q;
	// registered count-nonzero word
	logic [W-1:0] count_q;
	// previous live word for edge detection
	logic [W-1:0] live_prev_q;
	// previous count word for edge detection
	logic [W-1:0] count_prev_q;
	// edge detection armed after first sample
	logic armed_q;
	// first real sample taken since reset
	logic primed_q;
	// alignment currently in use
	logic [ALIGN_W-1:0] align_q;
	// an alignment has been loaded since reset
	logic align_valid_q;
	// latched outputs of the two sticky banks
	logic [W-1:0] latch1;
	logic [W-1:0] latch2;
	// set vectors for the sticky banks
	logic [W-1:0] set1;
	logic [W-1:0] set2;
	// write-one-to-clear vectors
	logic [W-1:0] clr1;
	logic [W-1:0] clr2;
	// forced zero for M23 mode
	logic [W-1:0] zero2;
	// combinational next values
	logic [W-1:0] live_d;
	logic [W-1:0] count_d;
	// selected framing error event
	logic framing_evt;
	// alignment differs from the one in use
	logic align_change;
	// m23 mode indicator
	logic m23_mode;
	// read data next value
	logic [W-1:0] rdata_d;

	assign m23_mode = ~i_cbit_mode;

	// assemble the live status word
	always_comb begin
		live_d = '0;
		live_d[rx_status_pkg::FORMAT_MISMATCH_BIT] = i_cbit_mode ^ i_app_id_channel;
		live_d[rx_status_pkg::APP_ID_CHANNEL_BIT] = i_app_id_channel;
		live_d[rx_status_pkg::QUIET_SIGNAL_BIT] = i_quiet_signal;
		live_d[rx_status_pkg::UNFRAMED_ONES_BIT] = i_unframed_all_ones;
		live_d[rx_status_pkg::MULTIFRAME_OUT_BIT] = i_multiframe_out;
		live_d[rx_status_pkg::SEVERE_FRAME_BIT] = i_severe_errored_frame;
		live_d[rx_status_pkg::FRAME_FAILURE_BIT] = i_frame_alignment_failure;
		live_d[rx_status_pkg::REMOTE_DEFECT_BIT] = i_remote_defect;
		live_d[rx_status_pkg::ALARM_IND_BIT] = i_alarm_indication;
		live_d[rx_status_pkg::OUT_OF_FRAMING_BIT] = i_out_of_framing;
		live_d[rx_status_pkg::SIGNAL_ABSENT_BIT] = i_signal_absent;
	end

	// assemble the count-nonzero word; m23 hides the C-bit pair
	always_comb begin
		count_d = '0;
		count_d[rx_status_pkg::CBIT_NZ_BIT] = i_cbit_cnt_nz & ~m23_mode;
		count_d[rx_status_pkg::FAR_BLOCK_NZ_BIT] = i_far_block_cnt_nz & ~m23_mode;
		count_d[rx_status_pkg::PBIT_NZ_BIT] = i_pbit_cnt_nz;
		count_d[rx_status_pkg::FRAMING_NZ_BIT] = i_framing_cnt_nz;
	end

	// pick the framing error event by the select field
	always_comb begin
		case (i_framing_err_count_select)
			rx_status_pkg::FE_SEL_OOF: begin
				framing_evt = i_oof_event;
			end
			rx_status_pkg::FE_SEL_M_AND_F: begin
				framing_evt = i_mbit_err | i_fbit_err;
			end
			rx_status_pkg::FE_SEL_F_ONLY: begin
				framing_evt = i_fbit_err;
			end
			rx_status_pkg::FE_SEL_M_ONLY: begin
				framing_evt = i_mbit_err;
			end
			default: begin
				framing_evt = 1'b0;
			end
		endcase
	end

	// live and count words sampled into flops
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			live_q <= '0;
			count_q <= '0;
		end else begin
			live_q <= live_d;
			count_q <= count_d;
		end
	end

	// previous copies used by the edge detectors
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			live_prev_q <= '0;
			count_prev_q <= '0;
			armed_q <= 1'b0;
			primed_q <= 1'b0;
		end else begin
			live_prev_q <= live_q;
			count_prev_q <= count_q;
			// history still holds reset zeros until the second edge,
			// so a condition already present is not reported as a change
			primed_q <= 1'b1;
			armed_q <= primed_q;
		end
	end

	// gated error pulses toward the external counters
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cbit_count_inc <= 1'b0;
			o_far_block_count_inc <= 1'b0;
			o_pbit_count_inc <= 1'b0;
			o_framing_count_inc <= 1'b0;
		end else begin
			// no C-bit or far-end counting in m23 mode
			o_cbit_count_inc <= i_cbit_parity_err & ~m23_mode;
			o_far_block_count_inc <= i_far_block_err & ~m23_mode;
			o_pbit_count_inc <= i_pbit_parity_err;
			o_framing_count_inc <= framing_evt;
		end
	end

	// alignment tracking; the first load has no predecessor to differ from
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			align_q <= '0;
			align_valid_q <= 1'b0;
		end else if (i_align_load) begin
			align_q <= i_align_value;
			align_valid_q <= 1'b1;
		end
	end

	assign align_change = i_align_load & align_valid_q & (i_align_value != align_q);

	// set vector of the first latched register
	always_comb begin
		set1 = '0;
		if (armed_q) begin
			// either edge of the change-tracked live bits
			set1 = (live_q ^ live_prev_q) & rx_status_pkg::CHANGE_MASK;
			// mismatch latch takes the rising edge only
			set1[rx_status_pkg::FORMAT_MISMATCH_BIT] =
				live_q[rx_status_pkg::FORMAT_MISMATCH_BIT] &
				~live_prev_q[rx_status_pkg::FORMAT_MISMATCH_BIT];
		end
		set1[rx_status_pkg::ALIGNMENT_CHANGE_BIT] = align_change;
	end

	// set vector of the second latched register
	always_comb begin
		set2 = '0;
		set2[rx_status_pkg::CBIT_ERR_BIT] = i_cbit_parity_err;
		set2[rx_status_pkg::FAR_BLOCK_ERR_BIT] = i_far_block_err;
		set2[rx_status_pkg::PBIT_ERR_BIT] = i_pbit_parity_err;
		set2[rx_status_pkg::FRAMING_ERR_BIT] = framing_evt;
		if (armed_q) begin
			// zero-to-one of each count-nonzero bit
			set2[rx_status_pkg::CBIT_NZ_BIT] =
				count_q[rx_status_pkg::CBIT_NZ_BIT] & ~count_prev_q[rx_status_pkg::CBIT_NZ_BIT];
			set2[rx_status_pkg::FAR_BLOCK_NZ_BIT] =
				count_q[rx_status_pkg::FAR_BLOCK_NZ_BIT] & ~count_prev_q[rx_status_pkg::FAR_BLOCK_NZ_BIT];
			set2[rx_status_pkg::PBIT_NZ_BIT] =
				count_q[rx_status_pkg::PBIT_NZ_BIT] & ~count_prev_q[rx_status_pkg::PBIT_NZ_BIT];
			set2[rx_status_pkg::FRAMING_NZ_BIT] =
				count_q[rx_status_pkg::FRAMING_NZ_BIT] & ~count_prev_q[rx_status_pkg::FRAMING_NZ_BIT];
		end
	end

	// m23 mode pins the C-bit and far-end latches at zero
	assign zero2 = m23_mode ? rx_status_pkg::M23_ZERO_MASK : '0;

	// software write-one-to-clear decode
	always_comb begin
		clr1 = '0;
		clr2 = '0;
		if (i_wr) begin
			// writes to read-only words are ignored
			if (i_addr == rx_status_pkg::RX_LATCHED_STATUS_OFS) begin
				clr1 = i_wdata & rx_status_pkg::LATCH1_MASK;
			end
			if (i_addr == rx_status_pkg::RX_LATCHED_ERRORS_OFS) begin
				clr2 = i_wdata & rx_status_pkg::LATCH2_MASK;
			end
		end
	end

	// first latched register
	sticky_bits #(
		.W(W)
	) u_latched_status (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_set(set1),
		.i_clr(clr1),
		.i_zero(~rx_status_pkg::LATCH1_MASK),
		.o_bits(latch1)
	);

	// second latched register
	sticky_bits #(
		.W(W)
	) u_latched_errors (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_set(set2),
		.i_clr(clr2),
		.i_zero(zero2 | ~rx_status_pkg::LATCH2_MASK),
		.o_bits(latch2)
	);

	// read multiplexer; unmapped offsets read as zero
	always_comb begin
		case (i_addr)
			rx_status_pkg::RX_LIVE_STATUS_OFS: begin
				rdata_d = live_q;
			end
			rx_status_pkg::RX_COUNT_STATUS_OFS: begin
				rdata_d = count_q;
			end
			rx_status_pkg::RX_LATCHED_STATUS_OFS: begin
				rdata_d = latch1;
			end
			rx_status_pkg::RX_LATCHED_ERRORS_OFS: begin
				rdata_d = latch2;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// read data held until the next read
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end
	end

	// one-cycle marker that o_rdata is fresh
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd;
		end
	end

	// live word mirrored for the rest of the framer
	assign o_live_status = live_q;

	// interrupt request; registered so it cannot glitch
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_int_req <= 1'b0;
		end else begin
			o_int_req <= i_port_int_en &
				(|(latch1 & i_status_int_en) | |(latch2 & i_errors_int_en));
		end
	end

endmodule

// ### verilog/rx_status_pkg.sv
package rx_status_pkg;

	// register data width
	localparam int REG_W = 16;
	// register address width
	localparam int ADDR_W = 10;

	// register offsets
	localparam logic [9:0] RX_LIVE_STATUS_OFS = 10'h124;
	localparam logic [9:0] RX_COUNT_STATUS_OFS = 10'h126;
	localparam logic [9:0] RX_LATCHED_STATUS_OFS = 10'h128;
	localparam logic [9:0] RX_LATCHED_ERRORS_OFS = 10'h12a;

	// live status bit positions
	localparam int FORMAT_MISMATCH_BIT = 11;
	localparam int APP_ID_CHANNEL_BIT = 10;
	localparam int QUIET_SIGNAL_BIT = 9;
	localparam int UNFRAMED_ONES_BIT = 8;
	localparam int MULTIFRAME_OUT_BIT = 7;
	localparam int SEVERE_FRAME_BIT = 6;
	localparam int ALIGNMENT_CHANGE_BIT = 5;
	localparam int FRAME_FAILURE_BIT = 4;
	localparam int REMOTE_DEFECT_BIT = 3;
	localparam int ALARM_IND_BIT = 2;
	localparam int OUT_OF_FRAMING_BIT = 1;
	localparam int SIGNAL_ABSENT_BIT = 0;

	// live bits that latch on either edge (all used except 11 and 5)
	localparam logic [15:0] CHANGE_MASK = 16'h07df;
	// implemented bits of the live and first latched registers
	localparam logic [15:0] LIVE_MASK = 16'h0fdf;
	localparam logic [15:0] LATCH1_MASK = 16'h0fff;

	// count-status and second latched register bit positions
	localparam int CBIT_NZ_BIT = 3;
	localparam int FAR_BLOCK_NZ_BIT = 2;
	localparam int PBIT_NZ_BIT = 1;
	localparam int FRAMING_NZ_BIT = 0;
	localparam int CBIT_ERR_BIT = 11;
	localparam int FAR_BLOCK_ERR_BIT = 10;
	localparam int PBIT_ERR_BIT = 9;
	localparam int FRAMING_ERR_BIT = 8;

	// bits forced to zero in M23 mode, second latched register
	localparam logic [15:0] M23_ZERO_MASK = 16'h0c0c;
	// implemented bits of the second latched register
	localparam logic [15:0] LATCH2_MASK = 16'h0f0f;

	// framing error select encodings
	localparam logic [1:0] FE_SEL_OOF = 2'h0;
	localparam logic [1:0] FE_SEL_M_AND_F = 2'h1;
	localparam logic [1:0] FE_SEL_F_ONLY = 2'h2;
	localparam logic [1:0] FE_SEL_M_ONLY = 2'h3;

	// default width of the frame alignment word
	localparam int ALIGN_W_DEFAULT = 12;

endpackage

// ### verilog/sticky_bits.sv
`timescale 1ns/1ps

// bank of write-one-to-clear sticky bits; set beats clear
module sticky_bits #(
	parameter int W = 16
) (
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	input wire logic [W-1:0] i_zero,
	output logic [W-1:0] o_bits
);

	// set wins over a same-cycle clear, forced zero wins over both
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bits <= '0;
		end else begin
			o_bits <= ((o_bits & ~i_clr) | i_set) & ~i_zero;
		end
	end

endmodule
